// *** core/tphb_core.sv ***
// Control logic of a three-channel half-bridge driver.
// Assumes analog comparators deliver over-current, over-temperature
// and supply-low levels asynchronously; gate drivers follow phaseDrive.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Each phase has its own high and low control input, independent.
// - Normal mode: 1/0 drives high, 0/1 drives low, 0/0 and 1/1 float.
// - Any protection state floats all three phases, inputs ignored.
// - Inputs sampled and outputs updated only on oscillator ticks; the code updates the flags and clears over-current counts on any system clock.
// - A rising control input takes effect after three oscillator ticks.
// - Oscillator tick rate nominally 9 MHz, within plus or minus 30 %.
// - Over-temperature floats outputs until its indication clears.
// - Motor supply low floats outputs; resumes once supply recovers.
// - Regulated supply low floats outputs; resumes once it recovers.
// - Over-current held qualification time on any switch floats all.
// - After over-current trip, outputs stay off for the restart term.
// - Separate open-drain flags for over-current and over-temperature.
module tphb_core #(
	parameter int RESTART_CYC = tphb_pkg::RESTART_CYCLES,
	parameter int QUAL_TICKS  = tphb_pkg::OC_QUAL_TICKS
) (
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// Phase control pins from the motor controller
	input  wire logic                     phase_a_high_ctrl,
	input  wire logic                     phase_a_low_ctrl,
	input  wire logic                     phase_b_high_ctrl,
	input  wire logic                     phase_b_low_ctrl,
	input  wire logic                     phase_c_high_ctrl,
	input  wire logic                     phase_c_low_ctrl,
	// Protection comparator levels
	input  wire logic [5:0]               current_sense_pin,
	input  wire logic                     overtemp_protect,
	input  wire logic                     motorSupplyLow,
	input  wire logic                     regulatedReferenceLow,
	// Gate drive per phase, both low means high impedance
	output var  tphb_pkg::tphb_pair_t [2:0] phaseDrive,
	// Open-drain detection flags
	output logic                          overcurrent_flag_out,
	output logic                          overcurrentFlagOe,
	output logic                          overtemp_flag_out,
	output logic                          overtempFlagOe
);
	import tphb_pkg::*;

	localparam int RST_W  = $clog2(RESTART_CYC + 1);
	localparam int QUAL_W = $clog2(QUAL_TICKS + 1);

	// Two-stage synchronisers for every pin level
	logic [SYNC_W-1:0] syncA_reg;
	logic [SYNC_W-1:0] syncB_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end else begin
			syncA_reg <= {regulatedReferenceLow, motorSupplyLow, overtemp_protect,
				current_sense_pin,
				phase_c_high_ctrl, phase_c_low_ctrl,
				phase_b_high_ctrl, phase_b_low_ctrl,
				phase_a_high_ctrl, phase_a_low_ctrl};
			syncB_reg <= syncA_reg;
		end
	end

	// Each phase commanded on its own pair of inputs
	tphb_pair_t [2:0] cmd;
	assign cmd = syncB_reg[5:0];
	logic [5:0] ocSense;
	assign ocSense = syncB_reg[11:6];
	logic otHot;
	logic vmLow;
	logic vregLow;
	assign otHot   = syncB_reg[12];
	assign vmLow   = syncB_reg[13];
	assign vregLow = syncB_reg[14];

	// Oscillator tick divider; nearest integer ratio keeps jitter nil
	logic [OSC_DIV_W-1:0] oscCnt_reg;
	logic [OSC_DIV_W-1:0] oscCnt_next;
	logic                 tick_reg;
	logic                 tick_next;

	always_comb begin
		tick_next = (oscCnt_reg == OSC_DIV_W'(OSC_DIV - 1));
		oscCnt_next = tick_next ? '0 : oscCnt_reg + OSC_DIV_W'(1);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oscCnt_reg <= '0;
			tick_reg   <= 1'b0;
		end else begin
			oscCnt_reg <= oscCnt_next;
			tick_reg   <= tick_next;
		end
	end

	// Per-switch over-current qualification counters in ticks
	logic [5:0] ocQual;

	genvar gs;
	generate
		for (gs = 0; gs < NUM_SWITCH; gs++) begin : g_oc
			logic [QUAL_W-1:0] cnt_reg;
			logic [QUAL_W-1:0] cnt_next;
			always_comb begin
				cnt_next = cnt_reg;
				if (!ocSense[gs])
					cnt_next = '0;
				else if (tick_reg && cnt_reg != QUAL_W'(QUAL_TICKS))
					cnt_next = cnt_reg + QUAL_W'(1);
			end
			always_ff @(posedge clk_sys) begin
				if (rst)
					cnt_reg <= '0;
				else
					cnt_reg <= cnt_next;
			end
			assign ocQual[gs] = (cnt_reg == QUAL_W'(QUAL_TICKS));
		end
	endgenerate

	// Over-current supervisor with restart hold timer
	tphb_prot_t       prot_reg;
	tphb_prot_t       prot_next;
	logic [RST_W-1:0] hold_reg;
	logic [RST_W-1:0] hold_next;

	always_comb begin
		prot_next = prot_reg;
		hold_next = hold_reg;
		unique case (prot_reg)
			PROT_RUN: begin
				if (|ocQual) begin
					prot_next = PROT_OC_HOLD;
					hold_next = RST_W'(RESTART_CYC - 1);
				end
			end
			PROT_OC_HOLD: begin
				// Restart term counted in system cycles
				if (hold_reg == '0)
					prot_next = PROT_RUN;
				else
					hold_next = hold_reg - RST_W'(1);
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prot_reg <= PROT_RUN;
			hold_reg <= '0;
		end else begin
			prot_reg <= prot_next;
			hold_reg <= hold_next;
		end
	end

	// Any protection state; supply faults also stop the control logic
	logic ocActive;
	logic uvActive;
	logic protActive;
	assign ocActive   = (prot_reg == PROT_OC_HOLD);
	assign uvActive   = vmLow | vregLow;
	assign protActive = ocActive | otHot | uvActive;

	// Dead-time state per phase: applied command and wait counter
	tphb_pair_t [2:0]  appl_reg;
	tphb_pair_t [2:0]  appl_next;
	logic [DEAD_W-1:0] dead_reg [NUM_PHASES];
	logic [DEAD_W-1:0] dead_next [NUM_PHASES];
	tphb_pair_t [2:0]  drive_next;

	// Half-bridge decode: only 1/0 and 0/1 switch a transistor on
	function automatic tphb_pair_t decodePair(input tphb_pair_t c);
		tphb_pair_t d;
		d.hi = c.hi & ~c.lo;
		d.lo = c.lo & ~c.hi;
		return d;
	endfunction : decodePair

	always_comb begin
		tphb_pair_t rises;
		rises = '0;
		for (int p = 0; p < NUM_PHASES; p++) begin
			appl_next[p]  = appl_reg[p];
			dead_next[p]  = dead_reg[p];
			drive_next[p] = phaseDrive[p];
			rises = cmd[p] & ~appl_reg[p];
			if (uvActive) begin
				// Control logic off: forget any pending command
				appl_next[p] = '0;
				dead_next[p] = '0;
			end else if (tick_reg) begin
				if (rises == '0) begin
					appl_next[p] = cmd[p];
					dead_next[p] = '0;
				end else if (dead_reg[p] == DEAD_W'(DEAD_TICKS - 1)) begin
					appl_next[p] = cmd[p];
					dead_next[p] = '0;
				end else begin
					// Falls act now, rises wait out the dead time
					appl_next[p] = appl_reg[p] & cmd[p];
					dead_next[p] = dead_reg[p] + DEAD_W'(1);
				end
			end
			if (tick_reg) begin
				if (protActive)
					drive_next[p] = '0;
				else
					drive_next[p] = decodePair(appl_reg[p]);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			appl_reg   <= '0;
			phaseDrive <= '0;
			for (int p = 0; p < NUM_PHASES; p++)
				dead_reg[p] <= '0;
		end else begin
			appl_reg   <= appl_next;
			phaseDrive <= drive_next;
			for (int p = 0; p < NUM_PHASES; p++)
				dead_reg[p] <= dead_next[p];
		end
	end

	// Flags pull low while active; pin level is always zero
	logic ocFlagOe_next;
	logic otFlagOe_next;

	always_comb begin
		ocFlagOe_next = ocActive;
		otFlagOe_next = otHot;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overcurrentFlagOe    <= 1'b0;
			overtempFlagOe       <= 1'b0;
			overcurrent_flag_out <= 1'b0;
			overtemp_flag_out    <= 1'b0;
		end else begin
			overcurrentFlagOe    <= ocFlagOe_next;
			overtempFlagOe       <= otFlagOe_next;
			overcurrent_flag_out <= 1'b0;
			overtemp_flag_out    <= 1'b0;
		end
	end

	// Checks
	sequence s_trip;
		(prot_reg == PROT_RUN) && (|ocQual);
	endsequence

	sequence s_hold8;
		(prot_reg == PROT_OC_HOLD) [*8];
	endsequence

	a_no_shoot: assert property (@(posedge clk_sys) disable iff (rst)
		!(phaseDrive[0].hi && phaseDrive[0].lo) && !(phaseDrive[1].hi && phaseDrive[1].lo)
		&& !(phaseDrive[2].hi && phaseDrive[2].lo))
		else $error("both switches of a phase on");

	a_map_high: assert property (@(posedge clk_sys) disable iff (rst)
		(tick_reg && !protActive && appl_reg[0] == 2'b10) |=> phaseDrive[0] == 2'b10)
		else $error("phase A not driven high");

	a_prot_float: assert property (@(posedge clk_sys) disable iff (rst)
		(tick_reg && protActive) |=> phaseDrive == '0)
		else $error("outputs not floated under protection");

	a_tick_only: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(tick_reg) |-> $stable(phaseDrive))
		else $error("output changed off an oscillator tick");

	a_tick_rate: assert property (@(posedge clk_sys) disable iff (rst)
		tick_reg |=> !tick_reg ##1 !tick_reg ##1 tick_reg)
		else $error("oscillator tick spacing wrong");

	a_dead_wait: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(appl_reg[0].hi) |-> $past(dead_reg[0]) == DEAD_W'(DEAD_TICKS - 1))
		else $error("rise applied before dead time");

	a_fall_fast: assert property (@(posedge clk_sys) disable iff (rst)
		(tick_reg && !uvActive && appl_reg[0].hi && !cmd[0].hi) |=> !appl_reg[0].hi)
		else $error("fall not applied at next tick");

	a_restart_hold: assert property (@(posedge clk_sys) disable iff (rst)
		s_trip |=> s_hold8)
		else $error("restart hold ended early");

	a_oc_flag: assert property (@(posedge clk_sys) disable iff (rst)
		s_trip |=> ##1 overcurrentFlagOe && !overcurrent_flag_out)
		else $error("over-current flag not pulled low");

	// A short hot pulse can fall between ticks, so floating is checked per tick
	a_ot_flag: assert property (@(posedge clk_sys) disable iff (rst)
		otHot |=> overtempFlagOe && !overtemp_flag_out)
		else $error("over-temperature flag not pulled low");

	a_ot_float: assert property (@(posedge clk_sys) disable iff (rst)
		(otHot && tick_reg) |=> phaseDrive == '0)
		else $error("over-temperature did not float outputs");
endmodule : tphb_core

`default_nettype wire

// *** pkg/tphb_pkg.sv ***
// Constants and carrier types for the three-phase half-bridge control.
// Assumes a single 25 MHz system clock; oscillator is an enable pulse.
package tphb_pkg;
	// System clock and internal oscillator rates
	localparam int CLK_FREQ_KHZ = 25000;
	localparam int OSC_FREQ_KHZ = 9000;
	// Nearest whole divider, 8.33 MHz, inside the +-30 % band
	localparam int OSC_DIV      = (CLK_FREQ_KHZ + OSC_FREQ_KHZ / 2) / OSC_FREQ_KHZ;
	localparam int OSC_DIV_W    = $clog2(OSC_DIV);

	// Turn-on delay after a rising control input, in oscillator ticks
	localparam int DEAD_TICKS   = 3;
	localparam int DEAD_W       = 2;

	// Over-current qualification time, least time rounds up
	localparam int OC_QUAL_NS    = 1000;
	localparam int OC_QUAL_TICKS = (OC_QUAL_NS * (OSC_FREQ_KHZ / 1000) + 999) / 1000;

	// Restart term = 0.313 x 31.5 x C x 1e6 seconds, C in farads
	localparam int RESTART_K_MILLI = 313;
	localparam int RESTART_K_TENTH = 315;
	localparam int RESTART_CAP_NF  = 1000;
	localparam int RESTART_US      = RESTART_K_MILLI * RESTART_K_TENTH * RESTART_CAP_NF / 10;
	localparam int RESTART_CYCLES  = RESTART_US * (CLK_FREQ_KHZ / 1000);

	// Structure sizes
	localparam int NUM_PHASES = 3;
	localparam int NUM_SWITCH = 6;
	localparam int SYNC_W     = 15;

	// One phase: high-side and low-side pair, for commands and drives
	typedef struct packed {
		logic hi;
		logic lo;
	} tphb_pair_t;

	// Over-current supervisor states
	typedef enum logic {
		PROT_RUN,
		PROT_OC_HOLD
	} tphb_prot_t;
endpackage : tphb_pkg

// *** verif/tphb_ctrl_model.sv ***
// Behavioural motor controller driving the six phase control pins.
// Assumes the bench sets the wanted command off the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tphb_ctrl_model
	import tphb_pkg::*;
(
	// Wanted command and supply state
	input  wire tphb_pkg::tphb_pair_t [2:0] cmd,
	input  wire logic                       supplyOff,
	// Control pins toward the block
	output logic                            phase_a_high_ctrl,
	output logic                            phase_a_low_ctrl,
	output logic                            phase_b_high_ctrl,
	output logic                            phase_b_low_ctrl,
	output logic                            phase_c_high_ctrl,
	output logic                            phase_c_low_ctrl
);
	// All pins low while the supply is off, a high pin would back-feed it
	assign {phase_c_high_ctrl, phase_c_low_ctrl, phase_b_high_ctrl, phase_b_low_ctrl,
		phase_a_high_ctrl, phase_a_low_ctrl} = supplyOff ? 6'h00 : cmd;
endmodule : tphb_ctrl_model
`default_nettype wire

// *** verif/tphb_core_bench.sv ***
// Self-checking bench for the half-bridge control core.
// Assumes short restart and qualification counts for simulation.
`timescale 1ns/1ps
`default_nettype none
module tphb_core_bench;
	import tphb_pkg::*;
	logic                 clk_sys;
	logic                 rst;
	logic [5:0]           cmd;
	logic [5:0]           current_sense_pin;
	logic                 overtemp_protect;
	logic                 motorSupplyLow;
	logic                 regulatedReferenceLow;
	logic                 supplyOff;
	logic                 aH, aL, bH, bL, cH, cL;
	tphb_pair_t [2:0]     phaseDrive;
	logic                 ocOut, ocOe, otOut, otOe;
	int                   err_total;
	int                   tests_run;

	// Far-side controller
	tphb_ctrl_model tphb_ctrl_model_i (.cmd(cmd), .supplyOff(supplyOff),
		.phase_a_high_ctrl(aH), .phase_a_low_ctrl(aL), .phase_b_high_ctrl(bH),
		.phase_b_low_ctrl(bL), .phase_c_high_ctrl(cH), .phase_c_low_ctrl(cL));

	// Short counts keep the run brief
	tphb_core #(.RESTART_CYC(20), .QUAL_TICKS(2)) tphb_core_i (.clk_sys(clk_sys), .rst(rst),
		.phase_a_high_ctrl(aH), .phase_a_low_ctrl(aL), .phase_b_high_ctrl(bH),
		.phase_b_low_ctrl(bL), .phase_c_high_ctrl(cH), .phase_c_low_ctrl(cL),
		.current_sense_pin(current_sense_pin), .overtemp_protect(overtemp_protect),
		.motorSupplyLow(motorSupplyLow), .regulatedReferenceLow(regulatedReferenceLow),
		.phaseDrive(phaseDrive), .overcurrent_flag_out(ocOut), .overcurrentFlagOe(ocOe),
		.overtemp_flag_out(otOut), .overtempFlagOe(otOe));

	// 25 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Drive expected per phase: only 10 and 01 are driven, any protection floats
	function automatic logic [5:0] expDrive(input logic [5:0] c, input logic off);
		logic [5:0] e;
		e = 6'h00;
		for (int p = 0; p < 3; p++) begin
			if (!off && (c[2*p+1] ^ c[2*p])) begin
				e[2*p+:2] = c[2*p+:2];
			end
		end
		return e;
	endfunction : expDrive

	task automatic check(input logic [5:0] seen, input logic [5:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// Inputs move only on the falling edge
	task automatic waitCyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : waitCyc

	task automatic results;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// Watchdog at 20000 cycles, far beyond the roughly 1050 cycles the tests need
	initial begin
		#(40 * 20000);
		err_total++;
		results();
	end

	// Main sequence
	initial begin
		int b;
		err_total = 0;
		tests_run = 0;
		rst = 1'b1;
		cmd = 6'h00;
		current_sense_pin = 6'h00;
		overtemp_protect = 1'b0;
		motorSupplyLow = 1'b0;
		regulatedReferenceLow = 1'b0;
		supplyOff = 1'b0;
		void'($urandom(83780));
		waitCyc(5);
		rst = 1'b0;
		waitCyc(2);
		check(phaseDrive, 6'h00, "idle after reset");
		// Every code on every phase, then random mixes
		for (int k = 0; k < 24; k++) begin
			cmd = (k < 4) ? {2'(k + 2), 2'(k + 1), 2'(k)} : 6'($urandom);
			waitCyc(20);
			check(phaseDrive, expDrive(cmd, 1'b0), "command table");
		end
		$display("Test command table done");
		// Rising edge waits out the dead time, falling edge does not
		cmd = 6'h00;
		waitCyc(20);
		cmd = 6'h02;
		waitCyc(8);
		check(phaseDrive, 6'h00, "dead time too short");
		waitCyc(12);
		check(phaseDrive, 6'h02, "rise not applied");
		cmd = 6'h00;
		waitCyc(8);
		check(phaseDrive, 6'h00, "fall late");
		$display("Test dead time done");
		// Over-temperature, motor supply low, regulated supply low, motor supply off
		// Supply low without supply off keeps the pins commanded, so only the lockout can float them
		for (int s = 0; s < 4; s++) begin
			cmd = 6'h19;
			waitCyc(20);
			overtemp_protect = (s == 0);
			motorSupplyLow = (s == 1) || (s == 3);
			regulatedReferenceLow = (s == 2);
			supplyOff = (s == 3);
			waitCyc(8);
			check(phaseDrive, 6'h00, "protection float");
			check({4'h0, otOe, ocOe}, {4'h0, s == 0, 1'b0}, "flag enables");
			check({4'h0, otOut, ocOut}, 6'h00, "flag data");
			overtemp_protect = 1'b0;
			motorSupplyLow = 1'b0;
			regulatedReferenceLow = 1'b0;
			supplyOff = 1'b0;
			waitCyc(25);
			check(phaseDrive, 6'h19, "resume");
			check({5'h00, otOe}, 6'h00, "flag release");
		end
		$display("Test protection levels done");
		// Over-current on each switch: glitch ignored, held trip, restart wait
		for (int j = 0; j < 7; j++) begin
			b = (j < 6) ? j : int'($urandom_range(5, 0));
			current_sense_pin = 6'h01 << b;
			waitCyc(1);
			current_sense_pin = 6'h00;
			waitCyc(10);
			check({5'h00, ocOe}, 6'h00, "glitch tripped");
			current_sense_pin = 6'h01 << b;
			waitCyc(12);
			check({5'h00, ocOe}, 6'h01, "no trip");
			check(phaseDrive, 6'h00, "trip float");
			current_sense_pin = 6'h00;
			// Hold of 20 cycles ends 27 to 29 cycles after the sense pin goes high; probe both sides
			waitCyc(15);
			check({5'h00, ocOe}, 6'h01, "restart early");
			waitCyc(5);
			check({5'h00, ocOe}, 6'h00, "restart late");
			check(phaseDrive, 6'h19, "resume after trip");
		end
		$display("Test over-current done");
		results();
	end
endmodule : tphb_core_bench
`default_nettype wire
